//--- design/mca_access.sv
// Memory-mapped tag and data array access for a four-way 8-kbyte cache
`timescale 1ns/1ps
// What this block does
// RULE1 - Bits 31..24 decode 0xF0 region as tag array, 0xF1 as data array.
// RULE2 - Only longword, non-fetch accesses are served; others are refused.
// RULE3 - Array reads and writes happen only in privileged mode.
// RULE4 - Entry index from address bits 10..4; 0xF0 tag, 0xF1 data.
// RULE5 - Normal mode: way field bits 12..11 select ways 0 to 3.
// RULE6 - RAM mode: way field 00/10 gives way 0, 01/11 gives way 1.
// RULE7 - Compare bit set: write only the matching way, ignore way field.
// RULE8 - Compare bit clear: write tag and flags straight to indexed way.
// RULE9 - Write-data bits 31..10 translated to physical when translation enabled.
// RULE10 - Tag read returns tag, valid, dirty, history of chosen entry.
// RULE11 - Clearing valid on a valid dirty entry writes the line back.
// RULE12 - Software clearing valid must clear dirty in the same write.
// RULE13 - Miss fills store zeros in the top three tag bits.
// RULE14 - Software must keep the top three tag bits at zero.
// RULE15 - Data access: bits 3..2 select longword 0 to 3 of the line.
// RULE16 - Data reads and writes move exactly one addressed longword.
// RULE17 - Compare all four ways in normal mode, ways 0 and 1 in RAM mode.
// RULE18 - Data-array writes leave tag, flags and history untouched.
module mca_access #(
    parameter int unsigned N_WAYS = mca_pkg::WAYS,
    parameter int unsigned N_SETS = mca_pkg::SETS
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // Mode and translation
    input  wire logic               ram_mode,
    input  wire logic               xlate_en,
    output      logic [31:10]       xlate_vaddr,
    input  wire logic [31:10]       xlate_paddr,
    // Core access
    input  wire mca_pkg::mca_req_s  core_req,
    output      logic               core_ack,
    output      logic               core_err,
    output      logic [31:0]        core_rdata,
    // Miss fill from the cache controller
    input  wire mca_pkg::mca_fill_s fill,
    // Write-back to memory
    output      mca_pkg::mca_wb_s   wb,
    input  wire logic               wb_ready
);
    import mca_pkg::*;

    // ==========================================================
    // Arrays (contents are not cleared by reset, except tag flags and history)
    mca_tag_s     tags_q  [N_WAYS][N_SETS];
    logic [31:0]  data_q  [N_WAYS][N_SETS][LWORDS];

    // ==========================================================
    // Decode
    logic        hit_tag;
    logic        hit_data;
    logic        legal;
    logic [6:0]  idx;
    logic [1:0]  way_sel;
    logic [1:0]  lw;
    logic        cmp_mode;
    logic [TAG_W-1:0] wtag;

    // Region and shape decode
    always_comb begin
        // RULE1 region decode
        hit_tag  = core_req.addr[REGION_HI:REGION_LO] == REGION_TAG;
        hit_data = core_req.addr[REGION_HI:REGION_LO] == REGION_DATA;
        // RULE2 longword only
        // RULE3 privileged only
        legal    = core_req.privileged && core_req.longword && !core_req.ifetch;
        // RULE4 entry index
        idx      = core_req.addr[IDX_HI:IDX_LO];
        // RULE15 longword select
        lw       = core_req.addr[LW_HI:LW_LO];
        cmp_mode = core_req.addr[CMP_BIT];
        // RULE5 normal way select
        way_sel  = core_req.addr[WAY_HI:WAY_LO];
        // RULE6 RAM mode folds ways
        if (ram_mode) begin
            way_sel = {1'b0, core_req.addr[WAY_LO]};
        end
    end

    // RULE9 translate tag field
    assign xlate_vaddr = core_req.wdata[TAG_HI:TAG_LO];
    assign wtag        = xlate_en ? xlate_paddr : core_req.wdata[TAG_HI:TAG_LO];

    // ==========================================================
    // Tag comparison over the indexed set
    logic [N_WAYS-1:0] match;
    genvar g;
    generate
        for (g = 0; g < N_WAYS; g++) begin : g_cmp
            // RULE17 RAM mode limits ways
            assign match[g] = (tags_q[g][idx].tag == wtag) && (!ram_mode || g < 2);
        end
    endgenerate

    logic       any_match;
    logic [1:0] match_way;
    // Priority pick of the matching way
    always_comb begin
        any_match = 1'b0;
        match_way = 2'b00;
        for (int i = N_WAYS - 1; i >= 0; i--) begin
            if (match[i]) begin
                any_match = 1'b1;
                match_way = 2'(i);
            end
        end
    end

    // ==========================================================
    // Access control
    logic        do_tag_wr;
    logic [1:0]  tgt_way;
    logic        do_data_wr;
    logic        ack_d;
    logic        err_d;
    logic [31:0] rdata_d;
    logic        ack_q;
    logic        err_q;
    logic [31:0] rdata_q;
    mca_tag_s    new_tag;
    mca_tag_s    old_tag;
    logic        wb_need;
    logic        stall;

    // A buffered write-back not yet accepted by wb_ready stalls any further eviction
    assign stall = wb.valid && !wb_ready;

    // Request handling and read data
    always_comb begin
        ack_d      = 1'b0;
        err_d      = 1'b0;
        rdata_d    = rdata_q;
        do_tag_wr  = 1'b0;
        do_data_wr = 1'b0;
        // RULE8 direct way when compare clear
        tgt_way    = way_sel;
        // RULE7 compare selects matching way
        if (cmp_mode) begin
            tgt_way = match_way;
        end
        old_tag       = tags_q[tgt_way][idx];
        new_tag.tag   = wtag;
        new_tag.valid = core_req.wdata[VALID_BIT];
        new_tag.dirty = core_req.wdata[DIRTY_BIT];
        new_tag.hist  = core_req.wdata[HIST_HI:HIST_LO];
        // RULE11 detect eviction of dirty line
        wb_need = old_tag.valid && old_tag.dirty && !new_tag.valid;
        // Not taken again while its answer stands, so a core may hold req until ack
        if (core_req.req && (hit_tag || hit_data) && !fill.valid && !ack_q) begin
            if (!legal) begin
                ack_d = 1'b1;
                err_d = 1'b1;
            end else if (hit_tag && core_req.write) begin
                if (!(wb_need && stall)) begin
                    ack_d = 1'b1;
                    // RULE7 no match means no change
                    do_tag_wr = !cmp_mode || any_match;
                end
            end else if (hit_tag) begin
                ack_d = 1'b1;
                // RULE10 tag read format
                rdata_d = {tags_q[way_sel][idx].tag, tags_q[way_sel][idx].hist, 2'b00,
                           tags_q[way_sel][idx].dirty, tags_q[way_sel][idx].valid};
            end else if (core_req.write) begin
                ack_d = 1'b1;
                // RULE16 single longword write
                do_data_wr = 1'b1;
            end else begin
                ack_d = 1'b1;
                // RULE16 single longword read
                rdata_d = data_q[way_sel][idx][lw];
            end
        end
    end

    // Answer registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= ack_d;
            err_q   <= err_d;
            rdata_q <= rdata_d;
        end
    end

    assign core_ack   = ack_q;
    assign core_err   = err_q;
    assign core_rdata = rdata_q;

    // ==========================================================
    // Write-back buffer
    mca_wb_s wb_d;
    // Capture an evicted line or retire the buffered one
    always_comb begin
        wb_d = wb;
        if (wb.valid && wb_ready) begin
            wb_d.valid = 1'b0;
        end
        // RULE11 write back dirty line
        if (do_tag_wr && wb_need) begin
            wb_d.valid = 1'b1;
            wb_d.paddr = {old_tag.tag, idx[5:0], 4'b0000}; // Tag already holds bit 10
            wb_d.line  = {data_q[tgt_way][idx][3], data_q[tgt_way][idx][2],
                          data_q[tgt_way][idx][1], data_q[tgt_way][idx][0]};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb <= '0;
        end else begin
            wb <= wb_d;
        end
    end

    // ==========================================================
    // Tag array write port; a fill wins over a software write
    logic                 tag_we;
    logic [1:0]           tag_wway;
    logic [6:0]           tag_widx;
    mca_tag_s             tag_wval;

    // Pick the single tag entry written this cycle
    always_comb begin
        tag_we   = 1'b0;
        tag_wway = tgt_way;
        tag_widx = idx;
        tag_wval = new_tag;
        if (fill.valid) begin
            tag_we         = 1'b1;
            tag_wway       = fill.way;
            tag_widx       = fill.index;
            // RULE13 zero shadow bits on fill
            tag_wval.tag   = {{SHADOW_W{1'b0}}, fill.paddr[TAG_HI-SHADOW_W:TAG_LO]};
            tag_wval.valid = 1'b1;
            tag_wval.dirty = 1'b0;
            tag_wval.hist  = tags_q[fill.way][fill.index].hist; // A fill keeps the history
        end else if (do_tag_wr) begin
            // RULE8 store tag and flags
            tag_we = 1'b1;
        end
    end

    // Tag array; reset clears flags and history, tags are kept
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int w = 0; w < N_WAYS; w++) begin
                for (int s = 0; s < N_SETS; s++) begin
                    tags_q[w][s].valid <= 1'b0;
                    tags_q[w][s].dirty <= 1'b0;
                    tags_q[w][s].hist  <= HIST_RST;
                end
            end
        end else if (tag_we) begin
            tags_q[tag_wway][tag_widx] <= tag_wval;
        end
    end

    // ==========================================================
    // Data array write port; a fill writes every lane, software one
    logic                 data_we;
    logic [1:0]           data_wway;
    logic [6:0]           data_widx;
    logic [LWORDS-1:0]    data_wmask;
    logic [32*LWORDS-1:0] data_wline;

    // Pick the entry and the longword lanes written this cycle
    always_comb begin
        data_we    = 1'b0;
        data_wway  = way_sel;
        data_widx  = idx;
        data_wmask = '0;
        data_wline = {LWORDS{core_req.wdata}};
        if (fill.valid) begin
            data_we    = 1'b1;
            data_wway  = fill.way;
            data_widx  = fill.index;
            data_wmask = '1;
            data_wline = fill.line;
        end else if (do_data_wr) begin
            // RULE16 one longword lane
            // RULE18 tags left untouched
            data_we        = 1'b1;
            data_wmask[lw] = 1'b1;
        end
    end

    // Data array; no reset, contents survive it
    always_ff @(posedge mclk) begin
        if (data_we) begin
            for (int k = 0; k < LWORDS; k++) begin
                if (data_wmask[k]) begin
                    data_q[data_wway][data_widx][k] <= data_wline[32*k +: 32];
                end
            end
        end
    end

endmodule : mca_access

//--- design/mca_pkg.sv
// Package for the memory-mapped cache access block: address fields, sizes, carriers
package mca_pkg;

    // ==========================================================
    // Geometry
    localparam int unsigned WAYS      = 4;
    localparam int unsigned SETS      = 128;
    localparam int unsigned LWORDS    = 4;
    localparam int unsigned TAG_W     = 22;
    localparam int unsigned HIST_W    = 6;

    // ==========================================================
    // Access address fields
    localparam int unsigned REGION_HI = 31;
    localparam int unsigned REGION_LO = 24;
    localparam logic [7:0]  REGION_TAG  = 8'hF0;
    localparam logic [7:0]  REGION_DATA = 8'hF1;
    localparam int unsigned IDX_HI    = 10;
    localparam int unsigned IDX_LO    = 4;
    localparam int unsigned WAY_HI    = 12;
    localparam int unsigned WAY_LO    = 11;
    localparam int unsigned CMP_BIT   = 3;
    localparam int unsigned LW_HI     = 3;
    localparam int unsigned LW_LO     = 2;

    // ==========================================================
    // Tag-array data word layout
    localparam int unsigned TAG_HI    = 31;
    localparam int unsigned TAG_LO    = 10;
    localparam int unsigned HIST_HI   = 9;
    localparam int unsigned HIST_LO   = 4;
    localparam int unsigned DIRTY_BIT = 1;
    localparam int unsigned VALID_BIT = 0;
    localparam int unsigned SHADOW_W  = 3;

    // Reset value of the tag history; TAG_RST is unused, reset keeps the tags
    localparam logic [TAG_W-1:0]  TAG_RST  = 22'h00_0000;
    localparam logic [HIST_W-1:0] HIST_RST = 6'h00;

    // One tag entry
    typedef struct packed {
        logic [TAG_W-1:0]  tag;
        logic              valid;
        logic              dirty;
        logic [HIST_W-1:0] hist;
    } mca_tag_s;

    // Core access request
    typedef struct packed {
        logic        req;
        logic        write;
        logic        privileged;
        logic        longword;
        logic        ifetch;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mca_req_s;

    // Line handed to memory for write-back
    typedef struct packed {
        logic        valid;
        logic [31:0] paddr;
        logic [127:0] line;
    } mca_wb_s;

    // Cache miss fill from the cache controller
    typedef struct packed {
        logic        valid;
        logic [6:0]  index;
        logic [1:0]  way;
        logic [31:0] paddr;
        logic [127:0] line;
    } mca_fill_s;

endpackage : mca_pkg

//--- verif/mca_access_sva.sv
// Port checker for the cache access block
`timescale 1ns/1ps
module mca_access_sva (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               rst_n,
    // Core side
    input wire mca_pkg::mca_req_s  core_req,
    input wire logic               core_ack,
    input wire logic               core_err,
    input wire logic [31:0]        core_rdata,
    // Fill and write-back
    input wire mca_pkg::mca_fill_s fill,
    input wire mca_pkg::mca_wb_s   wb,
    input wire logic               wb_ready
);
    import mca_pkg::*;
    logic rgn, ok, tk;
    // ==========================================================
    // Requests the block must take
    assign rgn = core_req.addr[31:24] inside {REGION_TAG, REGION_DATA};
    assign ok = core_req.privileged && core_req.longword && !core_req.ifetch;
    assign tk = core_req.req && rgn && !fill.valid && !(wb.valid && !wb_ready) && !core_ack;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Properties
    property p_ack; tk |=> core_ack; endproperty
    property p_other; core_req.req && !rgn |=> !core_ack; endproperty
    property p_err; tk && !ok |=> core_ack && core_err; endproperty
    property p_ok; tk && ok |=> !core_err; endproperty
    property p_tagrd; tk && ok && !core_req.write && !core_req.addr[24] |=> core_rdata[3:2] == 2'b00; endproperty
    property p_rhold; $changed(core_rdata) |-> core_ack; endproperty
    property p_wbhold; wb.valid && !wb_ready |=> wb.valid && $stable(wb.paddr) && $stable(wb.line); endproperty
    property p_wbal; wb.valid |-> wb.paddr[3:0] == 4'h0; endproperty
    a_ack: assert property (p_ack) else $error("ack missing after request");
    a_other: assert property (p_other) else $error("ack outside array regions");
    a_err: assert property (p_err) else $error("illegal access not refused");
    a_ok: assert property (p_ok) else $error("legal access refused");
    a_tagrd: assert property (p_tagrd) else $error("tag read bits 3 to 2 not zero");
    a_rhold: assert property (p_rhold) else $error("read data moved without ack");
    a_wbhold: assert property (p_wbhold) else $error("write-back dropped before ready");
    a_wbal: assert property (p_wbal) else $error("write-back address not line aligned");
    c_rd: cover property (tk && !core_req.write);
    c_err: cover property (core_ack && core_err);
    c_wb: cover property (wb.valid && wb_ready);
endmodule : mca_access_sva

//--- verif/mca_mem_model.sv
// Memory side model: tag translation and write-back acceptance
`timescale 1ns/1ps
module mca_mem_model #(
    parameter logic [31:10] XMASK = 22'h00_0100
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Translation
    input  wire logic [31:10]     xlate_vaddr,
    output      logic [31:10]     xlate_paddr,
    // Write-back
    input  wire mca_pkg::mca_wb_s wb,
    input  wire logic             slow,
    output      logic             wb_ready,
    output      mca_pkg::mca_wb_s wb_last
);
    import mca_pkg::*;
    logic [1:0] wait_q, wait_d;
    mca_wb_s    last_d;
    assign xlate_paddr = xlate_vaddr ^ XMASK;
    assign wb_ready = wb.valid && (!slow || wait_q == 2'h3);
    // Next wait count and captured line
    always_comb begin
        wait_d = (wb.valid && !wb_ready) ? wait_q + 2'h1 : 2'h0;
        last_d = (wb.valid && wb_ready) ? wb : wb_last;
    end
    // Registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 2'h0;
            wb_last <= '0;
        end else begin
            wait_q  <= wait_d;
            wb_last <= last_d;
        end
    end
endmodule : mca_mem_model

//--- verif/testbench.sv
// Bench for the memory-mapped cache access block
`timescale 1ns/1ps
module testbench;
    import mca_pkg::*;
    // ==========================================================
    // Signals
    logic         mclk = 1'b0;
    logic         rst_n = 1'b0;
    logic         ram_mode = 1'b0;
    logic         xlate_en = 1'b0;
    logic         slow = 1'b0;
    logic         core_ack, core_err, wb_ready, er;
    logic [31:0]  core_rdata, rd;
    logic [31:10] xv, xp;
    mca_req_s     core_req = '0;
    mca_fill_s    fill = '0;
    mca_wb_s      wb, wb_last;
    int           err_total = 0;
    int           n_compared = 0;
    // Clock
    always #20 mclk = ~mclk;
    // Block and memory side
    mca_access dut (.mclk, .rst_n, .ram_mode, .xlate_en, .xlate_vaddr(xv), .xlate_paddr(xp),
        .core_req, .core_ack, .core_err, .core_rdata, .fill, .wb, .wb_ready);
    mca_mem_model mem (.mclk, .rst_n, .xlate_vaddr(xv), .xlate_paddr(xp), .wb, .slow, .wb_ready, .wb_last);
    // ==========================================================
    // Helpers
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string s, input logic [127:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic lim(input int n);
        if (n >= 20) begin
            chk("wait", 0, 1);
            final_report();
        end
    endtask : lim
    function automatic logic [31:0] ad(input logic [7:0] r, input int w, i, x);
        return {r, 11'h000, w[1:0], i[6:0], x[1:0], 2'b00};
    endfunction : ad
    function automatic logic [31:0] tw(input logic [21:0] t, input logic [5:0] h, input logic d, v);
        return {3'b000, t[18:0], h, 2'b00, d, v};
    endfunction : tw
    // One core access; request held up to the edge that samples the answer
    task automatic acc(input logic wr, input logic [31:0] a, d, input logic [2:0] f = 3'b110);
        int n;
        @(posedge mclk);
        core_req <= {1'b1, wr, f, a, d};
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (core_ack === 1'b1) begin
                break;
            end
        end
        core_req.req <= 1'b0;
        lim(n);
        rd = core_rdata;
        er = core_err;
    endtask : acc
    // ==========================================================
    // Every way and longword, tag left alone, translated tag
    task automatic t_data;
        int w, l;
        acc(1, ad(REGION_TAG, 2, 5, 0), tw(22'h01_2345, 6'h38, 1, 1));
        for (w = 0; w < 16; w++) begin
            acc(1, ad(REGION_DATA, w / 4, 5, w % 4), 32'hD0A5_0000 + 32'(w));
        end
        for (w = 0; w < 16; w++) begin
            acc(0, ad(REGION_DATA, w / 4, 5, w % 4), '0);
            chk("data word", 32'hD0A5_0000 + 32'(w), rd);
        end
        acc(0, ad(REGION_TAG, 2, 5, 0), '0);
        chk("tag after data", tw(22'h01_2345, 6'h38, 1, 1), rd);
        xlate_en <= 1'b1;
        acc(1, ad(REGION_TAG, 1, 9, 0), tw(22'h00_2A5C, 6'h07, 0, 1));
        xlate_en <= 1'b0;
        acc(0, ad(REGION_TAG, 1, 9, 0), '0);
        chk("translated tag", tw(22'h00_2B5C, 6'h07, 0, 1), rd);
        $display("t_data done");
    endtask : t_data
    // Compare writes in four-way and two-way mode
    task automatic t_cmp;
        int w;
        for (w = 0; w < 4; w++) begin
            acc(1, ad(REGION_TAG, w, 12, 0), tw(22'(273 * (w + 1)), 6'h00, 0, 1));
        end
        acc(1, ad(REGION_TAG, 0, 12, 2), tw(22'h00_0333, 6'h3F, 0, 1));
        acc(1, ad(REGION_TAG, 0, 12, 2), tw(22'h00_0555, 6'h01, 0, 1));
        acc(0, ad(REGION_TAG, 0, 12, 0), '0);
        chk("no match kept", tw(22'h00_0111, 6'h00, 0, 1), rd);
        ram_mode <= 1'b1;
        acc(1, ad(REGION_TAG, 0, 12, 2), tw(22'h00_0333, 6'h38, 0, 1));
        acc(1, ad(REGION_TAG, 2, 12, 0), tw(22'h00_0666, 6'h20, 0, 1));
        ram_mode <= 1'b0;
        acc(0, ad(REGION_TAG, 2, 12, 0), '0);
        chk("matched way", tw(22'h00_0333, 6'h3F, 0, 1), rd);
        acc(0, ad(REGION_TAG, 0, 12, 0), '0);
        chk("two-way mapping", tw(22'h00_0666, 6'h20, 0, 1), rd);
        $display("t_cmp done");
    endtask : t_cmp
    // Dirty line invalidated, slow write-back, then refusals and fill
    task automatic t_misc;
        int n;
        slow <= 1'b1;
        acc(1, ad(REGION_TAG, 3, 20, 0), tw(22'h00_1234, 6'h00, 1, 1));
        for (n = 0; n < 4; n++) begin
            acc(1, ad(REGION_DATA, 3, 20, n), 32'hBEEF_0000 + 32'(n));
        end
        acc(1, ad(REGION_TAG, 3, 20, 0), tw(22'h00_1234, 6'h00, 0, 0));
        for (n = 0; n < 20 && wb_last.valid !== 1'b1; n++) begin
            @(posedge mclk);
        end
        lim(n);
        chk("wb address", {22'h00_1234, 6'h14, 4'h0}, wb_last.paddr);
        chk("wb line", {32'hBEEF_0003, 32'hBEEF_0002, 32'hBEEF_0001, 32'hBEEF_0000}, wb_last.line);
        acc(1, ad(REGION_DATA, 0, 5, 0), 32'hDEAD_0000, 3'b010);
        chk("user refused", 1, er);
        acc(1, ad(REGION_DATA, 0, 5, 0), 32'hDEAD_0000, 3'b100);
        chk("size refused", 1, er);
        acc(1, ad(REGION_DATA, 0, 5, 0), 32'hDEAD_0000, 3'b111);
        chk("fetch refused", 1, er);
        acc(0, ad(REGION_DATA, 0, 5, 0), '0);
        chk("array kept", 32'hD0A5_0000, rd);
        @(posedge mclk);
        core_req <= {1'b1, 1'b0, 3'b110, 32'hF200_0000, 32'h0000_0000};
        repeat (2) @(posedge mclk);
        chk("other region", 0, core_ack);
        core_req.req <= 1'b0;
        fill <= {1'b1, 7'h1E, 2'b01, 32'hE123_4560, 128'h0};
        @(posedge mclk);
        fill.valid <= 1'b0;
        acc(0, ad(REGION_TAG, 1, 30, 0), '0);
        chk("fill tag", {3'b000, 19'(32'hE123_4560 >> 10)}, rd[31:10]);
        $display("t_misc done");
    endtask : t_misc
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_data();
        t_cmp();
        t_misc();
        final_report();
    end
endmodule : testbench
bind mca_access mca_access_sva u_sva (.mclk, .rst_n, .core_req, .core_ack, .core_err, .core_rdata, .fill, .wb, .wb_ready);
